/* cg_pkg.sv */
package cg_pkg;
  // Register addresses
  localparam logic [6:0]  CG_ADDR_CLKGEN  = 7'h06;
  localparam logic [6:0]  CG_ADDR_RATE    = 7'h07;
  localparam logic [6:0]  CG_ADDR_LOOP1   = 7'h08;
  localparam logic [6:0]  CG_ADDR_LOOP2   = 7'h09;
  localparam logic [6:0]  CG_ADDR_LOOP3   = 7'h0a;
  // Reset values
  localparam logic [15:0] CG_CLKGEN_RST   = 16'h0006;
  localparam logic [3:0]  CG_RATE_RST     = 4'hd;
  localparam logic [12:0] CG_LOOP1_RST    = 13'h0102;
  localparam logic [15:0] CG_LOOP2_RST    = 16'h3137;
  localparam logic [9:0]  CG_LOOP_INT_RST = 10'h008;
  localparam logic [3:0]  CG_LOOP_GAIN_RST = 4'h4;
  // Field positions, clock generation control
  localparam int CG_OSC_EN_BIT   = 15;
  localparam int CG_PULL_LSB     = 13;
  localparam int CG_CO_SRC_BIT   = 12;
  localparam int CG_CO_DIV_LSB   = 10;
  localparam int CG_SYS_EN_BIT   = 9;
  localparam int CG_SYS_SRC_BIT  = 8;
  localparam int CG_SYS_DIV_LSB  = 5;
  localparam int CG_TO_EN_BIT    = 4;
  localparam int CG_BCLK_DIV_LSB = 1;
  localparam int CG_MASTER_BIT   = 0;
  // Field positions, loop control
  localparam int CG_REF_DIV_LSB  = 11;
  localparam int CG_OUT_DIV_LSB  = 8;
  localparam int CG_CRATE_LSB    = 5;
  localparam int CG_RATIO_LSB    = 2;
  localparam int CG_FRAC_BIT     = 1;
  localparam int CG_LOOP_EN_BIT  = 0;
  localparam int CG_INT_LSB      = 5;
  localparam int CG_GAIN_LSB     = 0;
  // Sample rate codes
  localparam logic [3:0]  CG_SR_8K    = 4'h3;
  localparam logic [3:0]  CG_SR_11K   = 4'h4;
  localparam logic [3:0]  CG_SR_12K   = 4'h5;
  localparam logic [3:0]  CG_SR_16K   = 4'h7;
  localparam logic [3:0]  CG_SR_22K   = 4'h8;
  localparam logic [3:0]  CG_SR_24K   = 4'h9;
  localparam logic [3:0]  CG_SR_32K   = 4'hb;
  localparam logic [3:0]  CG_SR_44K   = 4'hc;
  localparam logic [3:0]  CG_SR_48K   = 4'hd;
  // Pull codes
  localparam logic [1:0]  CG_PULL_DOWN = 2'h1;
  localparam logic [1:0]  CG_PULL_UP   = 2'h2;
  // Ratios in system clock ticks, half frame in bit clock ticks
  localparam logic [8:0]  CG_FS_LAST      = 9'h1ff;
  localparam logic [4:0]  CG_HALF_FRAME   = 5'h1f;
  localparam logic [2:0]  CG_DMIC_LAST_HI = 3'h3;
  localparam logic [2:0]  CG_DMIC_LAST_LO = 3'h7;
  // Timing
  localparam int CG_CLK_NS        = 8;
  localparam int CG_OSC_PERIOD_NS = 1000;
  localparam logic [6:0] CG_OSC_LAST = 7'(CG_OSC_PERIOD_NS / CG_CLK_NS - 1);
  localparam logic [5:0] CG_TO_LAST  = 6'h3f;
endpackage

/* cg_div_if.sv */
`timescale 1ns/1ps
interface cg_div_if;
  logic       in_tick;
  logic [4:0] ratio2;
  logic       out_tick;
  modport div  (input in_tick, input ratio2, output out_tick);
  modport user (output in_tick, output ratio2, input out_tick);
endinterface

/* cg_tick_div.sv */
`timescale 1ns/1ps
module cg_tick_div
  import cg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Divider link
  cg_div_if.div    dv
);
  // Half-unit accumulator gives the 1.5 ratio
  logic [5:0] acc, next_acc;
  logic [4:0] ratio_l, next_ratio_l;
  logic       next_out;
  logic [5:0] sum;

  always_comb begin
    sum          = acc + 6'h2;
    next_acc     = acc;
    next_ratio_l = ratio_l;
    next_out     = 1'b0;
    if (dv.in_tick) begin
      next_acc = sum;
      if (sum >= {1'b0, ratio_l}) begin
        next_out     = 1'b1; // R2
        next_acc     = sum - {1'b0, ratio_l};
        // New ratio only at a period boundary, so no runt period
        next_ratio_l = dv.ratio2; // R24
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc         <= 6'h0;
      ratio_l     <= 5'h2;
      dv.out_tick <= 1'b0;
    end else begin
      acc         <= next_acc;
      ratio_l     <= next_ratio_l;
      dv.out_tick <= next_out;
    end
  end

  div_one_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
    dv.in_tick && ratio_l == 5'h2 |=> dv.out_tick)
    else $error("Divide by one missed a tick");
  div_half_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
    dv.out_tick && $past(ratio_l) == 5'h3 |-> !$past(dv.out_tick) || acc == 6'h0)
    else $error("Divide by 1.5 pattern wrong");
endmodule

/* cg_clock_gen.sv */
`timescale 1ns/1ps
// Summary of operation
// R1: Source select: master clock or loop
// R2: System divider 1,1.5,2,3,4,6,8,12
// R3: Software sets system clock to 512 fs
// R4: System clock gated by its enable
// R5: Sample rate field picks nine rates
// R6: Converter paths share one sample rate
// R7: Master frame clock is bit clock/64
// R8: Clock-out auto enabled, source selectable
// R9: Clock-out divider 1,2,4,8
// R10: Software enables oscillator for timed functions
// R11: Timeout clock needs its enable and oscillator
// R12: Master clock pull none/down/up, 11 reserved
// R13: Mic clock 128fs low, 64fs high
// R14: Mic use needs converter clock settings
// R15: Disable loop while changing its settings
// R16: Reference divider 1,2,4,8 of master clock
// R17: Multiplier integer plus optional fraction
// R18: Loop output is ref*mult*ratio/outdiv
// R19: Software keeps loop between 90-100 MHz
// R20: Software picks output divider by target
// R21: Integer mode low power, fractional best
// R22: Control rate default, gain recommended
// R23: Ratio divider 1,2,4,8, else 16
// R24: Divider and source changes glitch free
module cg_clock_gen
  import cg_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Master clock pulse, one per period
  input  wire logic        mclk_tick,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // General pin configuration
  input  wire logic        gpio_clock_output_cfg,
  input  wire logic        gpio_dmic_cfg,
  // Clock pulses and levels
  output logic             system_clock,
  output logic             sample_tick,
  output logic             sample_rate_valid,
  output logic             bit_clock,
  output logic             frame_clock,
  output logic             clock_output,
  output logic             digital_mic_clock,
  output logic             loop_out_tick,
  output logic             osc_tick,
  output logic             timeout_tick,
  // Analogue controls
  output logic             mclk_pull_up,
  output logic             mclk_pull_down,
  output logic      [2:0]  loop_control_rate,
  output logic      [3:0]  loop_gain
);
  // Register group
  logic [15:0] clkgen, next_clkgen;
  logic [3:0]  sample_rate_select, next_sample_rate_select;
  logic [12:0] loop1, next_loop1;
  logic [15:0] loop_fraction_multiplier, next_loop_fraction_multiplier;
  logic [9:0]  loop_integer_multiplier, next_loop_integer_multiplier;
  logic [3:0]  next_loop_gain;
  logic [15:0] next_rdata;

  always_comb begin
    next_clkgen                   = clkgen;
    next_sample_rate_select       = sample_rate_select;
    next_loop1                    = loop1;
    next_loop_fraction_multiplier = loop_fraction_multiplier;
    next_loop_integer_multiplier  = loop_integer_multiplier;
    next_loop_gain                = loop_gain;
    if (reg_wr) begin
      unique case (reg_addr)
        CG_ADDR_CLKGEN: next_clkgen = reg_wdata;
        CG_ADDR_RATE:   next_sample_rate_select = reg_wdata[3:0];
        CG_ADDR_LOOP1:  next_loop1 = reg_wdata[12:0];
        CG_ADDR_LOOP2:  next_loop_fraction_multiplier = reg_wdata;
        CG_ADDR_LOOP3: begin
          next_loop_integer_multiplier = reg_wdata[CG_INT_LSB +: 10];
          next_loop_gain               = reg_wdata[CG_GAIN_LSB +: 4];
        end
        default: ;
      endcase
    end
    unique case (reg_addr)
      CG_ADDR_CLKGEN: next_rdata = clkgen;
      CG_ADDR_RATE:   next_rdata = {12'h0, sample_rate_select};
      CG_ADDR_LOOP1:  next_rdata = {3'h0, loop1};
      CG_ADDR_LOOP2:  next_rdata = loop_fraction_multiplier;
      CG_ADDR_LOOP3:  next_rdata = {1'b0, loop_integer_multiplier, 1'b0, loop_gain};
      default:        next_rdata = 16'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clkgen                   <= CG_CLKGEN_RST;
      sample_rate_select       <= CG_RATE_RST;
      loop1                    <= CG_LOOP1_RST;
      loop_fraction_multiplier <= CG_LOOP2_RST;
      loop_integer_multiplier  <= CG_LOOP_INT_RST;
      loop_gain                <= CG_LOOP_GAIN_RST;
      reg_rdata                <= 16'h0;
    end else begin
      clkgen                   <= next_clkgen;
      sample_rate_select       <= next_sample_rate_select;
      loop1                    <= next_loop1;
      loop_fraction_multiplier <= next_loop_fraction_multiplier;
      loop_integer_multiplier  <= next_loop_integer_multiplier;
      loop_gain                <= next_loop_gain;
      reg_rdata                <= next_rdata;
    end
  end

  logic       loop_enable;
  logic [1:0] loop_reference_divider;
  logic [2:0] loop_output_divider, loop_ratio_divider;
  logic       loop_fractional_mode;
  assign loop_enable            = loop1[CG_LOOP_EN_BIT];
  assign loop_reference_divider = loop1[CG_REF_DIV_LSB +: 2];
  assign loop_output_divider    = loop1[CG_OUT_DIV_LSB +: 3];
  assign loop_ratio_divider     = loop1[CG_RATIO_LSB +: 3];
  assign loop_fractional_mode   = loop1[CG_FRAC_BIT];
  assign loop_control_rate      = loop1[CG_CRATE_LSB +: 3];

  // Loop group: numeric oscillator standing in for the analogue loop
  logic [2:0]  ref_cnt, next_ref_cnt;
  logic [31:0] credit, next_credit;
  logic        next_loop_out_tick, ref_tick, emit;
  logic [2:0]  ref_mask, ratio_shift;
  logic [25:0] mult;
  logic [29:0] inc;
  logic [31:0] thr;

  always_comb begin
    ref_mask    = 3'((4'h1 << loop_reference_divider) - 4'h1);
    ref_tick    = mclk_tick && ((ref_cnt & ref_mask) == ref_mask); // R16
    ratio_shift = loop_ratio_divider[2] ? 3'h4 : {1'b0, loop_ratio_divider[1:0]}; // R23
    mult        = {loop_integer_multiplier,
                   loop_fractional_mode ? loop_fraction_multiplier : 16'h0}; // R17
    inc         = {4'h0, mult} << ratio_shift;
    thr         = {7'h0, 9'd2 << loop_output_divider, 16'h0};
    emit        = loop_enable && (credit >= thr);
    next_ref_cnt       = mclk_tick ? ref_cnt + 3'h1 : ref_cnt;
    next_credit        = credit + (ref_tick ? {2'h0, inc} : 32'h0) - (emit ? thr : 32'h0); // R18
    next_loop_out_tick = emit; // R18
    if (!loop_enable) begin
      // Clearing the enable resets the loop state
      next_ref_cnt = 3'h0; // R15
      next_credit  = 32'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_cnt       <= 3'h0;
      credit        <= 32'h0;
      loop_out_tick <= 1'b0;
    end else begin
      ref_cnt       <= next_ref_cnt;
      credit        <= next_credit;
      loop_out_tick <= next_loop_out_tick;
    end
  end

  // Clock group
  cg_div_if sys_if ();
  cg_div_if co_if ();
  cg_tick_div u_sys_div (.ref_clk(ref_clk), .rstn(rstn), .dv(sys_if.div));
  cg_tick_div u_co_div  (.ref_clk(ref_clk), .rstn(rstn), .dv(co_if.div));

  logic       src_sel, next_src_sel, src_tick;
  logic [8:0] fs_cnt, next_fs_cnt;
  logic [4:0] bclk_cnt, next_bclk_cnt, frame_cnt, next_frame_cnt;
  logic [2:0] dmic_cnt, next_dmic_cnt, dmic_last, bclk_code;
  logic [6:0] osc_cnt, next_osc_cnt;
  logic [5:0] to_cnt, next_to_cnt;
  logic [4:0] bclk_mask;
  logic       bclk_int, next_frame_clock, next_osc_tick, next_timeout_tick;
  logic       next_system_clock, next_sample_tick, next_dmic, next_rate_valid;

  assign src_tick        = src_sel ? loop_out_tick : mclk_tick; // R1
  assign sys_if.in_tick  = src_tick;
  assign co_if.in_tick   = clkgen[CG_CO_SRC_BIT] ? src_tick : system_clock; // R8
  assign co_if.ratio2    = 5'h2 << clkgen[CG_CO_DIV_LSB +: 2]; // R9

  always_comb begin
    unique case (clkgen[CG_SYS_DIV_LSB +: 3]) // R2
      3'h0: sys_if.ratio2 = 5'd2;
      3'h1: sys_if.ratio2 = 5'd3;
      3'h2: sys_if.ratio2 = 5'd4;
      3'h3: sys_if.ratio2 = 5'd6;
      3'h4: sys_if.ratio2 = 5'd8;
      3'h5: sys_if.ratio2 = 5'd12;
      3'h6: sys_if.ratio2 = 5'd16;
      3'h7: sys_if.ratio2 = 5'd24;
    endcase
    // Switch source only between pulses of both, never mid-pulse
    next_src_sel = (mclk_tick || loop_out_tick) ? src_sel : clkgen[CG_SYS_SRC_BIT]; // R24
    next_system_clock = sys_if.out_tick && clkgen[CG_SYS_EN_BIT]; // R4
    // One sample tick serves both converter paths
    next_fs_cnt      = system_clock ? fs_cnt + 9'h1 : fs_cnt; // R6
    next_sample_tick = system_clock && fs_cnt == CG_FS_LAST;
    next_rate_valid  = sample_rate_select inside {CG_SR_8K, CG_SR_11K, CG_SR_12K, // R5
      CG_SR_16K, CG_SR_22K, CG_SR_24K, CG_SR_32K, CG_SR_44K, CG_SR_48K};
    // Reserved bit clock codes fall back to the slowest ratio
    bclk_code      = (clkgen[CG_BCLK_DIV_LSB +: 3] > 3'h5) ? 3'h5 : clkgen[CG_BCLK_DIV_LSB +: 3];
    bclk_mask      = 5'((6'h1 << bclk_code) - 6'h1);
    bclk_int       = system_clock && ((bclk_cnt & bclk_mask) == bclk_mask);
    next_bclk_cnt  = system_clock ? bclk_cnt + 5'h1 : bclk_cnt;
    next_frame_cnt   = 5'h0;
    next_frame_clock = 1'b0;
    if (clkgen[CG_MASTER_BIT]) begin
      next_frame_cnt   = bclk_int ? frame_cnt + 5'h1 : frame_cnt;
      next_frame_clock = frame_clock ^ (bclk_int && frame_cnt == CG_HALF_FRAME); // R7
    end
    dmic_last     = (sample_rate_select >= CG_SR_32K) ? CG_DMIC_LAST_LO : CG_DMIC_LAST_HI; // R13
    next_dmic_cnt = system_clock ? ((dmic_cnt >= dmic_last) ? 3'h0 : dmic_cnt + 3'h1) : dmic_cnt;
    next_dmic     = gpio_dmic_cfg && system_clock && dmic_cnt >= dmic_last; // R13
    next_osc_cnt  = 7'h0;
    next_osc_tick = 1'b0;
    if (clkgen[CG_OSC_EN_BIT]) begin
      next_osc_cnt  = (osc_cnt == CG_OSC_LAST) ? 7'h0 : osc_cnt + 7'h1; // R10
      next_osc_tick = osc_cnt == CG_OSC_LAST;
    end
    next_to_cnt       = to_cnt;
    next_timeout_tick = 1'b0;
    if (clkgen[CG_TO_EN_BIT] && next_osc_tick) begin
      next_to_cnt       = to_cnt + 6'h1; // R11
      next_timeout_tick = to_cnt == CG_TO_LAST;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      src_sel           <= 1'b0;
      system_clock      <= 1'b0;
      fs_cnt            <= 9'h0;
      sample_tick       <= 1'b0;
      sample_rate_valid <= 1'b0;
      bclk_cnt          <= 5'h0;
      bit_clock         <= 1'b0;
      frame_cnt         <= 5'h0;
      frame_clock       <= 1'b0;
      clock_output      <= 1'b0;
      dmic_cnt          <= 3'h0;
      digital_mic_clock <= 1'b0;
      osc_cnt           <= 7'h0;
      osc_tick          <= 1'b0;
      to_cnt            <= 6'h0;
      timeout_tick      <= 1'b0;
      mclk_pull_up      <= 1'b0;
      mclk_pull_down    <= 1'b0;
    end else begin
      src_sel           <= next_src_sel;
      system_clock      <= next_system_clock;
      fs_cnt            <= next_fs_cnt;
      sample_tick       <= next_sample_tick;
      sample_rate_valid <= next_rate_valid;
      bclk_cnt          <= next_bclk_cnt;
      bit_clock         <= bclk_int;
      frame_cnt         <= next_frame_cnt;
      frame_clock       <= next_frame_clock;
      clock_output      <= co_if.out_tick && gpio_clock_output_cfg; // R8
      dmic_cnt          <= next_dmic_cnt;
      digital_mic_clock <= next_dmic;
      osc_cnt           <= next_osc_cnt;
      osc_tick          <= next_osc_tick;
      to_cnt            <= next_to_cnt;
      timeout_tick      <= next_timeout_tick;
      mclk_pull_up      <= clkgen[CG_PULL_LSB +: 2] == CG_PULL_UP; // R12
      mclk_pull_down    <= clkgen[CG_PULL_LSB +: 2] == CG_PULL_DOWN; // R12
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sys_gate_a: assert property (!clkgen[CG_SYS_EN_BIT] |=> !system_clock) // R4
    else $error("System clock ran while disabled");
  frame_toggle_a: assert property ($rose(frame_clock) // R7
    |-> bit_clock && $past(clkgen[CG_MASTER_BIT]))
    else $error("Frame clock moved without master mode");
  frame_slave_a: assert property (!clkgen[CG_MASTER_BIT] |=> !frame_clock) // R7
    else $error("Frame clock driven in slave mode");
  co_gate_a: assert property (!gpio_clock_output_cfg |=> !clock_output) // R8
    else $error("Clock output without pin configuration");
  dmic_gate_a: assert property (digital_mic_clock |-> $past(gpio_dmic_cfg) // R13
    && $past(system_clock))
    else $error("Mic clock without cause");
  pull_resv_a: assert property (clkgen[CG_PULL_LSB +: 2] == 2'h3 // R12
    |=> !mclk_pull_up && !mclk_pull_down)
    else $error("Reserved pull code drove a pull");
  loop_off_a: assert property (!loop_enable ##1 !loop_enable |-> !loop_out_tick // R15
    && credit == 32'h0)
    else $error("Loop active while disabled");
  timeout_a: assert property (timeout_tick |-> $past(clkgen[CG_TO_EN_BIT]) // R11
    && $past(clkgen[CG_OSC_EN_BIT]))
    else $error("Timeout tick without both enables");
  rate_bad_a: assert property (sample_rate_select == 4'h0 |=> !sample_rate_valid) // R5
    else $error("Invalid rate code flagged valid");

  loop_run_c: cover property (loop_enable ##1 loop_out_tick);
  frame_run_c: cover property ($rose(frame_clock));
  dmic_hi_c: cover property (digital_mic_clock && sample_rate_select == CG_SR_48K);
  co_src_c: cover property (clock_output && clkgen[CG_CO_SRC_BIT]);
endmodule

/* cg_clock_gen_tb.sv */
`timescale 1ns/1ps
module tb
  import cg_pkg::*;
;
  logic        ref_clk;
  logic        rstn;
  logic        mclk_tick;
  logic        mclk_en;
  logic        reg_wr;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        gpio_clock_output_cfg;
  logic        gpio_dmic_cfg;
  logic        system_clock;
  logic        sample_tick;
  logic        sample_rate_valid;
  logic        bit_clock;
  logic        frame_clock;
  logic        clock_output;
  logic        digital_mic_clock;
  logic        loop_out_tick;
  logic        osc_tick;
  logic        timeout_tick;
  logic        mclk_pull_up;
  logic        mclk_pull_down;
  logic [2:0]  loop_control_rate;
  logic [3:0]  loop_gain;
  logic [8:0]  mon;
  int          failures;
  int          n_checks;

  cg_clock_gen dut (
    .ref_clk(ref_clk), .rstn(rstn), .mclk_tick(mclk_tick), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .gpio_clock_output_cfg(gpio_clock_output_cfg), .gpio_dmic_cfg(gpio_dmic_cfg),
    .system_clock(system_clock), .sample_tick(sample_tick),
    .sample_rate_valid(sample_rate_valid), .bit_clock(bit_clock),
    .frame_clock(frame_clock), .clock_output(clock_output),
    .digital_mic_clock(digital_mic_clock), .loop_out_tick(loop_out_tick),
    .osc_tick(osc_tick), .timeout_tick(timeout_tick), .mclk_pull_up(mclk_pull_up),
    .mclk_pull_down(mclk_pull_down), .loop_control_rate(loop_control_rate),
    .loop_gain(loop_gain)
  );

  assign mon = {bit_clock, timeout_tick, osc_tick, sample_tick, frame_clock, digital_mic_clock,
                clock_output, loop_out_tick, system_clock};

  always #4 ref_clk = ~ref_clk;

  // Master clock at half the bench clock, so loop and source gaps exist
  always @(posedge ref_clk) begin
    #1 mclk_tick <= mclk_en & ~mclk_tick;
  end

  task automatic conclude;
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(reg_rdata, exp);
  endtask

  // Window lengths are whole output periods, so counts do not depend on phase
  task automatic cnt(input int sel, input int ncyc, input logic [15:0] exp);
    int   n;
    logic prev;
    n    = 0;
    prev = mon[sel];
    repeat (ncyc) begin
      @(posedge ref_clk);
      #1;
      if (sel == 4) n += int'(mon[4] !== prev);
      else n += int'(mon[sel] === 1'b1);
      prev = mon[sel];
    end
    chk(16'(n), exp);
  endtask

  task automatic cfg(input logic [15:0] w);
    wr(CG_ADDR_CLKGEN, w);
    repeat (40) @(posedge ref_clk);
  endtask

  function automatic logic [15:0] sysw(input logic [2:0] div, input logic src);
    return 16'h0200 | (16'(div) << CG_SYS_DIV_LSB) | (16'(src) << CG_SYS_SRC_BIT);
  endfunction

  task automatic t_regs;
    rd(CG_ADDR_CLKGEN, 16'h0006);
    rd(CG_ADDR_RATE, 16'h000d);
    rd(CG_ADDR_LOOP1, 16'h0102);
    rd(CG_ADDR_LOOP2, 16'h3137);
    rd(CG_ADDR_LOOP3, 16'h0104);
    rd(7'h0b, 16'h0000);
    chk({9'h000, loop_control_rate, loop_gain}, 16'h0004);
    wr(CG_ADDR_RATE, 16'hffff);
    rd(CG_ADDR_RATE, 16'h000f);
    wr(CG_ADDR_LOOP3, 16'hffff);
    rd(CG_ADDR_LOOP3, 16'h7fef);
    wr(7'h0b, 16'hffff);
    rd(7'h0b, 16'h0000);
    wr(CG_ADDR_RATE, {12'h000, CG_SR_48K});
  endtask

  task automatic t_sysdiv;
    logic [15:0] exp [8] = '{16'h30, 16'h20, 16'h18, 16'h10, 16'hc, 16'h8, 16'h6, 16'h4};
    for (int c = 0; c < 8; c++) begin
      cfg(sysw(3'(c), 1'b0));
      cnt(0, 96, exp[c]);
    end
    cfg(16'h0000);
    cnt(0, 96, 16'h0000);
  endtask

  task automatic loop_set(input logic [15:0] ctl, input logic [9:0] n, input logic [15:0] k);
    wr(CG_ADDR_LOOP1, ctl & 16'hfffe);
    wr(CG_ADDR_LOOP2, k);
    wr(CG_ADDR_LOOP3, {1'b0, n, 5'h00});
    wr(CG_ADDR_LOOP1, ctl | 16'h0001);
    repeat (40) @(posedge ref_clk);
  endtask

  task automatic t_loop;
    // {refdiv, outdiv, ratio, frac} control words with N, K, expected ticks
    logic [15:0] ctl [7] = '{16'h0200, 16'h0900, 16'h0304, 16'h0200, 16'h0306,
                             16'h0310, 16'h031c};
    logic [9:0]  nv  [7] = '{10'd8, 10'd8, 10'd8, 10'd8, 10'd7, 10'd1, 10'd1};
    logic [15:0] kv  [7] = '{16'h0, 16'h0, 16'h0, 16'h8000, 16'h8000, 16'h0, 16'h0};
    logic [15:0] ev  [7] = '{16'd48, 16'd48, 16'd48, 16'd48, 16'd45, 16'd48, 16'd48};
    for (int i = 0; i < 7; i++) begin
      loop_set(ctl[i], nv[i], kv[i]);
      cnt(1, 96, ev[i]);
    end
    loop_set(16'h0300, 10'd8, 16'h0000);
    cnt(1, 96, 16'd24);
    cfg(sysw(3'h0, 1'b1));
    cnt(0, 96, 16'd24);
    wr(CG_ADDR_LOOP1, 16'h0300);
    repeat (4) @(posedge ref_clk);
    cnt(1, 96, 16'd0);
  endtask

  task automatic t_clock_output;
    logic [15:0] exp [4] = '{16'd24, 16'd12, 16'd6, 16'd3};
    cfg(sysw(3'h2, 1'b0));
    cnt(2, 96, 16'd0);
    gpio_clock_output_cfg = 1'b1;
    for (int c = 0; c < 4; c++) begin
      cfg(sysw(3'h2, 1'b0) | (16'(c) << CG_CO_DIV_LSB));
      cnt(2, 96, exp[c]);
    end
    cfg(sysw(3'h2, 1'b0) | (16'h1 << CG_CO_SRC_BIT));
    cnt(2, 96, 16'd48);
    gpio_clock_output_cfg = 1'b0;
  endtask

  task automatic t_rate;
    logic [3:0] code [9] = '{CG_SR_8K, CG_SR_11K, CG_SR_12K, CG_SR_16K, CG_SR_22K,
                             CG_SR_24K, CG_SR_32K, CG_SR_44K, CG_SR_48K};
    cfg(sysw(3'h0, 1'b0));
    cnt(3, 96, 16'd0);
    gpio_dmic_cfg = 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(CG_ADDR_RATE, {12'h000, code[i]});
      repeat (40) @(posedge ref_clk);
      chk({15'h0, sample_rate_valid}, 16'h1);
      cnt(3, 96, (i < 6) ? 16'd12 : 16'd6);
    end
    wr(CG_ADDR_RATE, 16'h0000);
    repeat (4) @(posedge ref_clk);
    chk({15'h0, sample_rate_valid}, 16'h0);
    wr(CG_ADDR_RATE, {12'h000, CG_SR_48K});
    gpio_dmic_cfg = 1'b0;
    cnt(5, 2048, 16'd2);
  endtask

  task automatic t_frame;
    cfg(sysw(3'h0, 1'b0) | 16'h0001);
    cnt(4, 256, 16'd4);
    cnt(8, 256, 16'd128);
    cfg(sysw(3'h0, 1'b0) | 16'h0003);
    cnt(4, 256, 16'd2);
    cnt(8, 256, 16'd64);
    // Reserved bit clock code falls back to the slowest ratio
    cfg(sysw(3'h0, 1'b0) | 16'h000f);
    cnt(8, 256, 16'd4);
    cfg(sysw(3'h0, 1'b0));
    chk({15'h0, frame_clock}, 16'h0);
  endtask

  task automatic t_osc;
    cfg(16'h8000);
    cnt(6, 1000, 16'd8);
    cfg(16'h8010);
    cnt(7, 16000, 16'd2);
    cfg(16'h0010);
    cnt(7, 8200, 16'd0);
    cnt(6, 250, 16'd0);
  endtask

  task automatic t_pull;
    for (int c = 0; c < 4; c++) begin
      cfg(16'(c) << CG_PULL_LSB);
      chk({14'h0, mclk_pull_up, mclk_pull_down}, (c == 3) ? 16'h0 : 16'(c));
    end
  endtask

  initial begin
    #500000;
    failures++;
    conclude();
  end

  initial begin
    ref_clk         = 1'b0;
    rstn            = 1'b0;
    mclk_en         = 1'b0;
    mclk_tick       = 1'b0;
    reg_wr          = 1'b0;
    reg_addr        = 7'h00;
    reg_wdata       = 16'h0000;
    gpio_clock_output_cfg = 1'b0;
    gpio_dmic_cfg   = 1'b0;
    failures        = 0;
    n_checks        = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    rstn    = 1'b1;
    mclk_en = 1'b1;
    t_regs();
    t_sysdiv();
    t_loop();
    t_clock_output();
    t_rate();
    t_frame();
    t_osc();
    t_pull();
    conclude();
  end
endmodule
